// ---- logic/sensor_bus_pkg.sv ----
// Package for the sensor bus slave framer: word formats, timing, codes
package sensor_bus_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int LONG_BITS = 20;
    localparam int SHORT_BITS = 12;
    localparam int CRC_BITS = 4;
    localparam logic [3:0] CRC_SEED = 4'h_A;
    localparam int TIMEOUT_US = 500;
    localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int POR_MASK_US = 10;
    localparam int POR_MASK_CYC = POR_MASK_US * (CLK_HZ / 1_000_000);
    localparam logic [3:0] CMD_INIT = 4'h_0;
    localparam logic [3:0] CMD_CLEAR = 4'h_1;
    localparam logic [3:0] CMD_IO_CTRL = 4'h_2;
    localparam logic [3:0] CMD_IO_READ = 4'h_3;
    localparam logic [3:0] CMD_REQ_AN0 = 4'h_4;
    localparam logic [3:0] CMD_REQ_AN1 = 4'h_5;
    localparam logic [3:0] CMD_TEST = 4'h_E;
    localparam logic [3:0] CMD_TEST_REG = 4'h_F;
    localparam logic [9:0] ADC10_MIN = 10'h_020;
    localparam logic [9:0] ADC10_MAX = 10'h_3E3;
    localparam logic [9:0] ADC10_ERR = 10'h_3F8;
    localparam logic [7:0] ADC8_MIN = 8'h_08;
    localparam logic [7:0] ADC8_MAX = 8'h_F8;
    localparam logic [7:0] ADC8_ERR = 8'h_FE;
    localparam int IO_PINS = 3;
    localparam int IO_ERR_PIN = 1;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic [3:0] cmd;
        logic is_long;
    } command_t;

    typedef struct packed {
        logic [IO_PINS-1:0] o;
        logic [IO_PINS-1:0] oe;
    } gpio_drive_t;

    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic b);
        // X^4+1: feedback into bit 0 only
        crc_step = {c[2:0], c[3] ^ b};
    endfunction : crc_step
endpackage : sensor_bus_pkg

// ---- logic/sensor_bus_slave.sv ----
// Slave word framer, CRC check, pipelined response and daisy-chain switch control
// Behaviour
// - Open switches isolate upstream and downstream lines
// - Closed switches stay closed until clear command, bus timeout or long power-on reset
// - Bus timeout resets device and opens switches
// - Long power-on reset resets; short ones filtered
// - Only initialization command closes opened switches
// - Power-up or clear makes all pins inputs
// - I/O control command sets each pin direction
// - 10-bit result clamped to range or error
// - 8-bit result clamped to range or error
// - Capture 4-bit address at initialization
// - Test mode needs pin, command, register access
// - Test output active only in test mode
// - Test accesses interleave with normal commands
// - Words separated by frame delay
// - Response sent during following command word
// - Corrupted word: no response, pending discarded
// - Long word: data, address, command, CRC
// - Short word: address, command, CRC
// - Long-form data ignored for either-size commands
// - Bitwise CRC, X^4+1, seed 1010, fixed
// - Act on word only if CRC matches
// - Wrong bit count is an error
// - Bit value from low versus high time
// - Current source on whole bit for one
// - Second pin input high forces error code
`timescale 1ns/10ps
`default_nettype none
module sensor_bus_slave
#(
    parameter int TIMEOUT_CYCLES = sensor_bus_pkg::TIMEOUT_CYC,
    parameter int POR_MASK_CYCLES = sensor_bus_pkg::POR_MASK_CYC
)
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Bus comparators and power monitor
    input wire logic I_BELOW_FRAME,
    input wire logic I_BELOW_SIGNAL,
    input wire logic I_POR_LOW,
    // Converter interface
    input wire logic [9:0] I_ADC_RAW,
    input wire logic I_ADC_FAULT,
    // General pins and test
    input wire logic [sensor_bus_pkg::IO_PINS-1:0] I_GPIO,
    input wire logic I_TEST_ENABLE_PIN,
    // Outputs
    output logic O_SWITCH_CLOSED,
    output logic O_RESPONSE_CURRENT,
    output sensor_bus_pkg::gpio_drive_t O_GPIO,
    output logic O_TEST_OBSERVE_OUT,
    output logic O_TEST_MODE,
    output logic [3:0] O_ADDRESS,
    output logic O_WORD_VALID,
    output sensor_bus_pkg::command_t O_COMMAND
);
    import sensor_bus_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Internal resets: bus timeout and filtered power-on reset
    logic [$clog2(TIMEOUT_CYCLES+1)-1:0] timeout_cnt;
    logic [$clog2(POR_MASK_CYCLES+1)-1:0] por_cnt;
    logic soft_rst;
    logic bus_timeout;
    logic por_long;

    assign bus_timeout = I_BELOW_FRAME && (timeout_cnt == TIMEOUT_CYCLES[$bits(timeout_cnt)-1:0]);
    assign por_long = I_POR_LOW && (por_cnt == POR_MASK_CYCLES[$bits(por_cnt)-1:0]);
    assign soft_rst = bus_timeout || por_long;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            timeout_cnt <= '0;
        else if (!I_BELOW_FRAME)
            timeout_cnt <= '0;
        else if (!bus_timeout)
            timeout_cnt <= timeout_cnt + 1'b1;
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            por_cnt <= '0;
        else if (!I_POR_LOW)
            por_cnt <= '0;
        else if (!por_long)
            por_cnt <= por_cnt + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit decoder: compare low time with high time
    typedef enum logic [1:0] {IDLE, BIT_LOW, BIT_HIGH} rx_state_t;
    rx_state_t rx_state;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [4:0] bit_cnt;
    logic [19:0] shreg;
    logic [3:0] crc;
    logic bit_done;
    logic bit_val;
    logic in_frame;
    logic frame_end;
    logic frame_done;

    assign in_frame = I_BELOW_FRAME;
    assign bit_val = high_cnt > low_cnt;
    assign bit_done = (rx_state == BIT_HIGH) && (I_BELOW_SIGNAL || !in_frame);
    assign frame_end = (rx_state != IDLE) && !in_frame;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            rx_state <= IDLE;
            low_cnt <= '0;
            high_cnt <= '0;
        end
        else if (soft_rst)
            rx_state <= IDLE;
        else
        begin
            unique case (rx_state)
                IDLE:
                begin
                    low_cnt <= '0;
                    high_cnt <= '0;
                    if (in_frame && I_BELOW_SIGNAL)
                        rx_state <= BIT_LOW;
                end
                BIT_LOW:
                begin
                    if (!in_frame)
                        rx_state <= IDLE;
                    else if (I_BELOW_SIGNAL)
                        low_cnt <= low_cnt + 1'b1;
                    else
                    begin
                        high_cnt <= 16'h_0001;
                        rx_state <= BIT_HIGH;
                    end
                end
                BIT_HIGH:
                begin
                    if (!in_frame)
                        rx_state <= IDLE;
                    else if (I_BELOW_SIGNAL)
                    begin
                        low_cnt <= 16'h_0001;
                        high_cnt <= '0;
                        rx_state <= BIT_LOW;
                    end
                    else
                        high_cnt <= high_cnt + 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word assembly and running CRC
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            bit_cnt <= '0;
            shreg <= '0;
            crc <= CRC_SEED;
        end
        else if (soft_rst || rx_state == IDLE)
        begin
            bit_cnt <= '0;
            crc <= CRC_SEED;
        end
        else if (bit_done)
        begin
            if (bit_cnt != 5'h_1F)
                bit_cnt <= bit_cnt + 1'b1;
            shreg <= {shreg[18:0], bit_val};
            if (bit_cnt < 5'(LONG_BITS - CRC_BITS))
                crc <= crc_step(crc, bit_val);
        end
    end

    // Judge the word one cycle after frame end, once the last bit is shifted in
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            frame_done <= 1'b0;
        else
            frame_done <= frame_end && !soft_rst;
    end

    // Check length and CRC at the end of the word
    logic len_long;
    logic len_short;
    logic crc_ok;
    logic word_ok;
    logic word_bad;
    logic [3:0] crc_chk;

    always_comb
    begin
        crc_chk = CRC_SEED;
        for (int i = 0; i < SHORT_BITS - CRC_BITS; i++)
            crc_chk = crc_step(crc_chk, shreg[SHORT_BITS - 1 - i]);
    end

    assign len_long = bit_cnt == 5'(LONG_BITS);
    assign len_short = bit_cnt == 5'(SHORT_BITS);
    assign crc_ok = len_long ? (crc == shreg[3:0]) : (crc_chk == shreg[3:0]);
    assign word_ok = frame_done && (len_long || len_short) && crc_ok;
    assign word_bad = frame_done && !word_ok;

    command_t cmd;
    assign cmd.data = len_long ? shreg[19:12] : 8'h_00;
    assign cmd.addr = shreg[11:8];
    assign cmd.cmd = shreg[7:4];
    assign cmd.is_long = len_long;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_WORD_VALID <= 1'b0;
            O_COMMAND <= '0;
        end
        else
        begin
            O_WORD_VALID <= word_ok && !soft_rst;
            if (word_ok)
                O_COMMAND <= cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device state: switches, address, pin directions, test mode
    logic initialized;
    logic test_armed;
    logic addr_hit;
    assign addr_hit = initialized && (cmd.addr == O_ADDRESS);

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_SWITCH_CLOSED <= 1'b0;
            initialized <= 1'b0;
            O_ADDRESS <= '0;
            O_GPIO <= '0;
            test_armed <= 1'b0;
            O_TEST_MODE <= 1'b0;
        end
        else if (soft_rst)
        begin
            O_SWITCH_CLOSED <= 1'b0;
            initialized <= 1'b0;
            O_GPIO <= '0;
            test_armed <= 1'b0;
            O_TEST_MODE <= 1'b0;
        end
        else if (word_ok)
        begin
            if (cmd.cmd == CMD_INIT && !initialized)
            begin
                O_ADDRESS <= cmd.addr;
                initialized <= 1'b1;
                O_SWITCH_CLOSED <= 1'b1;
            end
            else if (addr_hit)
            begin
                unique case (cmd.cmd)
                    CMD_CLEAR:
                    begin
                        O_SWITCH_CLOSED <= 1'b0;
                        initialized <= 1'b0;
                        O_GPIO <= '0;
                        test_armed <= 1'b0;
                        O_TEST_MODE <= 1'b0;
                    end
                    CMD_IO_CTRL:
                    begin
                        O_GPIO.oe <= cmd.data[IO_PINS+3:4];
                        O_GPIO.o <= cmd.data[IO_PINS-1:0];
                    end
                    CMD_TEST:
                        test_armed <= I_TEST_ENABLE_PIN;
                    CMD_TEST_REG:
                        if (test_armed && I_TEST_ENABLE_PIN)
                            O_TEST_MODE <= 1'b1;
                    default:
                        O_TEST_MODE <= O_TEST_MODE;
                endcase
            end
        end
        else if (!I_TEST_ENABLE_PIN)
        begin
            test_armed <= 1'b0;
            O_TEST_MODE <= 1'b0;
        end
    end

    assign O_TEST_OBSERVE_OUT = O_TEST_MODE && O_COMMAND.data[0];

    ////////////////////////////////////////////////////////////////////////
    // Converter result mapping
    logic [9:0] adc10;
    logic [7:0] adc8;
    logic adc_err;
    assign adc_err = I_ADC_FAULT || (!O_GPIO.oe[IO_ERR_PIN] && I_GPIO[IO_ERR_PIN]);

    always_comb
    begin
        if (adc_err)
            adc10 = ADC10_ERR;
        else if (I_ADC_RAW < ADC10_MIN)
            adc10 = ADC10_MIN;
        else if (I_ADC_RAW > ADC10_MAX)
            adc10 = ADC10_MAX;
        else
            adc10 = I_ADC_RAW;
        if (adc_err)
            adc8 = ADC8_ERR;
        else if (I_ADC_RAW[9:2] < ADC8_MIN)
            adc8 = ADC8_MIN;
        else if (I_ADC_RAW[9:2] > ADC8_MAX)
            adc8 = ADC8_MAX;
        else
            adc8 = I_ADC_RAW[9:2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Response build and shift-out during the next word
    logic [15:0] resp_data;
    logic [19:0] tx_shift;
    logic tx_pending;
    logic tx_active;
    logic [3:0] resp_crc;

    always_comb
    begin
        resp_data = '0;
        if (cmd.cmd == CMD_REQ_AN0 || cmd.cmd == CMD_REQ_AN1)
            resp_data = len_long ? {6'h_00, adc10} : {8'h_00, adc8};
        else if (cmd.cmd == CMD_IO_READ)
            resp_data = {13'h_0000, I_GPIO};
        else
            resp_data = {12'h_000, cmd.cmd};
        resp_crc = CRC_SEED;
        for (int i = 15; i >= 0; i--)
            if (len_long || i < 8)
                resp_crc = crc_step(resp_crc, resp_data[i]);
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            tx_shift <= '0;
            tx_pending <= 1'b0;
            tx_active <= 1'b0;
            O_RESPONSE_CURRENT <= 1'b0;
        end
        else if (soft_rst)
        begin
            tx_pending <= 1'b0;
            tx_active <= 1'b0;
            O_RESPONSE_CURRENT <= 1'b0;
        end
        else if (word_bad)
        begin
            tx_pending <= 1'b0;
            tx_active <= 1'b0;
            O_RESPONSE_CURRENT <= 1'b0;
        end
        else if (word_ok)
        begin
            tx_active <= 1'b0;
            O_RESPONSE_CURRENT <= 1'b0;
            tx_pending <= addr_hit && cmd.cmd != CMD_CLEAR;
            tx_shift <= len_long ? {resp_data, resp_crc} : {resp_data[7:0], resp_crc, 8'h_00};
        end
        else if (!in_frame)
            O_RESPONSE_CURRENT <= 1'b0;
        else if (rx_state == IDLE && I_BELOW_SIGNAL && tx_pending)
        begin
            tx_active <= 1'b1;
            tx_pending <= 1'b0;
            O_RESPONSE_CURRENT <= tx_shift[19];
            tx_shift <= {tx_shift[18:0], 1'b0};
        end
        else if (tx_active && rx_state == BIT_HIGH && I_BELOW_SIGNAL)
        begin
            O_RESPONSE_CURRENT <= tx_shift[19];
            tx_shift <= {tx_shift[18:0], 1'b0};
        end
    end

    // downstream lines follow upstream only via O_SWITCH_CLOSED in the analog switch
endmodule : sensor_bus_slave
`default_nettype wire

// ---- sim/bus_master.sv ----
// Bus master model driving command words on the sensor bus
`timescale 1ns/10ps
`default_nettype none
module bus_master
(
    // Clock and response current
    input wire logic i_clk,
    input wire logic i_rsp,
    // Comparator levels seen by the slave
    output logic o_below_frame,
    output logic o_below_signal
);
    logic [19:0] heard = '0;
    initial
    begin
        o_below_frame = 1'b0;
        o_below_signal = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Sends n bits of w MSB first and gathers the reply bits
    task automatic send(input logic [19:0] w, input int n);
        heard = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_below_frame = 1'b1;
            o_below_signal = 1'b1;
            repeat (w[i] ? 1 : 2) @(posedge i_clk);
            #1 o_below_signal = 1'b0;
            repeat (w[i] ? 2 : 1) @(posedge i_clk);
            #1 heard = {heard[18:0], i_rsp};
        end
        hold(0);
    endtask : send
    // Frame level held n cycles, then the idle gap between words
    task automatic hold(input int n);
        o_below_frame = 1'b1;
        if (n > 0)
        begin
            repeat (n) @(posedge i_clk);
            #1;
        end
        o_below_frame = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : hold
endmodule : bus_master
`default_nettype wire

// ---- sim/dsi_slave_frame_logic_bench.sv ----
// Self-checking bench for the sensor bus slave framer
`timescale 1ns/10ps
`default_nettype none
module dsi_slave_frame_logic_bench;
    import sensor_bus_pkg::*;
    localparam int TO = 100;
    localparam int PM = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic frm;
    logic sig;
    logic por = 1'b0;
    logic [9:0] raw = '0;
    logic flt = 1'b0;
    logic [2:0] pins = '0;
    logic [2:0] pin_w;
    logic tpin = 1'b0;
    logic sw;
    logic rsp;
    gpio_drive_t gp;
    logic tobs;
    logic tmode;
    logic [3:0] adr;
    logic wv;
    command_t cmd;
    int errors = 0;
    int comparisons = 0;
    int seed = 72869;
    int k;
    logic [3:0] a;
    logic [7:0] d;
    logic [2:0] moe = '0;
    logic [19:0] e;
    always #20 clk = ~clk;
    assign pin_w = (gp.oe & gp.o) | (~gp.oe & pins);
    sensor_bus_slave #(.TIMEOUT_CYCLES(TO), .POR_MASK_CYCLES(PM)) sensor_bus_slave_i (
        .I_CLK(clk), .I_RST(rst), .I_BELOW_FRAME(frm), .I_BELOW_SIGNAL(sig), .I_POR_LOW(por),
        .I_ADC_RAW(raw), .I_ADC_FAULT(flt), .I_GPIO(pin_w), .I_TEST_ENABLE_PIN(tpin),
        .O_SWITCH_CLOSED(sw), .O_RESPONSE_CURRENT(rsp), .O_GPIO(gp), .O_TEST_OBSERVE_OUT(tobs),
        .O_TEST_MODE(tmode), .O_ADDRESS(adr), .O_WORD_VALID(wv), .O_COMMAND(cmd));
    bus_master bus_master_i (.i_clk(clk), .i_rsp(rsp), .o_below_frame(frm), .o_below_signal(sig));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] crc(input logic [15:0] v, input int nb);
        logic [3:0] x;
        x = 4'h_A;
        for (int i = nb - 1; i >= 0; i--)
            x = {x[2:0], x[3] ^ v[i]};
        crc = x;
    endfunction : crc
    // Expected converter reply for the present inputs
    function automatic logic [19:0] adc(input logic lng);
        logic [9:0] v;
        logic [7:0] b;
        v = raw < 10'h_020 ? 10'h_020 : (raw > 10'h_3E3 ? 10'h_3E3 : raw);
        b = raw[9:2] < 8'h_08 ? 8'h_08 : (raw[9:2] > 8'h_F8 ? 8'h_F8 : raw[9:2]);
        if (flt || (pins[1] && !moe[1]))
        begin
            v = 10'h_3F8;
            b = 8'h_FE;
        end
        adc = lng ? {6'h_00, v, crc({6'h_00, v}, 16)} : {8'h_00, b, crc({8'h_00, b}, 8)};
    endfunction : adc
    // Word send; cut 1 spoils the check bits, cut 2 drops a bit
    task automatic tx(input logic [7:0] dd, input logic [3:0] aa, cc, input logic lng, input int cut);
        logic [15:0] v;
        v = lng ? {dd, aa, cc} : {8'h_00, aa, cc};
        bus_master_i.send({v, crc(v, lng ? 16 : 8) ^ {3'h0, cut == 1}}, (lng ? 20 : 12) - (cut == 2));
    endtask : tx
    task automatic chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
        comparisons++;
        if (got !== ex)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1_000_000;
        errors++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        chk("reset state", 0, {sw, gp, tmode, adr});
        a = 4'($random(seed));
        tx(0, a, CMD_INIT, 0, 0);
        chk("init", {1'b1, a}, {sw, adr});
        tx(0, ~a, CMD_INIT, 0, 0);
        chk("second init", a, adr);
        tx(0, a, CMD_CLEAR, 0, 1);
        tx(0, a, CMD_CLEAR, 0, 2);
        chk("bad words", 1, sw);
        for (k = 0; k < 3; k++)
        begin
            d = 8'($random(seed));
            tx(d, a, CMD_IO_CTRL, 1, 0);
            moe = d[6:4];
            chk("pin drive", {d[6:4], d[2:0]}, {gp.oe, gp.o});
        end
        for (k = 0; k < 8; k++)
        begin
            raw = (k < 4) ? 10'(k * 341) : 10'($random(seed));
            flt = k == 5;
            pins = 3'($random(seed));
            tx(0, a, (k[0] ? CMD_REQ_AN1 : CMD_REQ_AN0), k[1], 0);
            e = adc(k[1]);
            tx(0, a, CMD_REQ_AN0, k[1], 0);
            chk("converter reply", e, bus_master_i.heard);
        end
        tx(0, a, CMD_REQ_AN0, 0, 0);
        e = adc(0);
        tx(0, a, CMD_REQ_AN0, 0, 1);
        tx(0, a, CMD_REQ_AN0, 0, 0);
        chk("reply after bad word", 0, bus_master_i.heard);
        tx(0, a, CMD_REQ_AN0, 0, 0);
        chk("reply after resend", e, bus_master_i.heard);
        tx(0, a, CMD_TEST_REG, 0, 0);
        chk("test mode unarmed", 0, tmode);
        tpin = 1'b1;
        tx(0, a, CMD_TEST, 0, 0);
        tx(8'h_01, a, CMD_TEST_REG, 1, 0);
        chk("test mode", 2'b11, {tmode, tobs});
        tx(8'h_70, a, CMD_IO_CTRL, 1, 0);
        chk("command in test mode", 3'h7, gp.oe);
        tpin = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("test exit", 0, {tmode, tobs});
        tx(0, a, CMD_CLEAR, 0, 0);
        moe = 3'h0;
        chk("clear", 0, {sw, gp.oe});
        tx(8'h_70, a, CMD_IO_CTRL, 1, 0);
        chk("uninitialised", 0, gp.oe);
        tx(0, a, CMD_INIT, 0, 0);
        bus_master_i.hold(TO + 10);
        chk("bus timeout", {1'b0, a}, {sw, adr});
        tx(0, a, CMD_INIT, 0, 0);
        for (k = 0; k < 2; k++)
        begin
            por = 1'b1;
            repeat (k ? PM + 5 : PM - 2) @(posedge clk);
            #1 por = 1'b0;
            repeat (4) @(posedge clk);
            #1 chk("supply dip", !k, sw);
        end
        close_out();
    end
endmodule : dsi_slave_frame_logic_bench
`default_nettype wire

// ---- sim/sensor_bus_properties.sv ----
// Concurrent checks on the sensor bus slave ports
`timescale 1ns/10ps
`default_nettype none
module sensor_bus_properties
#(
    parameter int TIMEOUT_CYCLES = 100,
    parameter int POR_MASK_CYCLES = 5
)
(
    // Clock, reset and stimulus
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_BELOW_FRAME,
    input wire logic I_POR_LOW,
    input wire logic I_TEST_ENABLE_PIN,
    // Observed outputs
    input wire logic O_SWITCH_CLOSED,
    input wire logic O_RESPONSE_CURRENT,
    input wire sensor_bus_pkg::gpio_drive_t O_GPIO,
    input wire logic O_TEST_OBSERVE_OUT,
    input wire logic O_TEST_MODE,
    input wire logic [3:0] O_ADDRESS,
    input wire logic O_WORD_VALID,
    input wire sensor_bus_pkg::command_t O_COMMAND
);
    import sensor_bus_pkg::*;
    int fc;
    int pc;
    logic cause;
    logic own;
    ////////////////////////////////////////////////////////////////////////////////
    // Lengths of frame-low and supply-dip spells
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            fc <= 0;
            pc <= 0;
        end
        else
        begin
            fc <= I_BELOW_FRAME ? fc + 1 : 0;
            pc <= I_POR_LOW ? pc + 1 : 0;
        end
    end
    assign cause = fc >= TIMEOUT_CYCLES || pc >= POR_MASK_CYCLES;
    assign own = O_WORD_VALID && O_COMMAND.addr == O_ADDRESS;
    ////////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    rsp_idle_a: assert property ((!I_BELOW_FRAME) [*2] |-> !O_RESPONSE_CURRENT)
        else $error("response current outside a frame");
    valid_timing_a: assert property (O_WORD_VALID |-> !$past(I_BELOW_FRAME) &&
        ($past(I_BELOW_FRAME, 3) || $past(I_BELOW_FRAME, 4)) ##1 !O_WORD_VALID)
        else $error("word valid pulse misplaced");
    switch_close_a: assert property ($rose(O_SWITCH_CLOSED) |-> ##[0:1]
        (O_WORD_VALID && O_COMMAND.cmd == CMD_INIT && O_ADDRESS == O_COMMAND.addr))
        else $error("switch closed without init");
    stay_closed_a: assert property ($fell(O_SWITCH_CLOSED) |-> (cause || $past(cause)) or
        (##[0:1] (O_WORD_VALID && O_COMMAND.cmd == CMD_CLEAR)))
        else $error("switch opened without cause");
    timeout_open_a: assert property (fc == TIMEOUT_CYCLES + 3 |-> !O_SWITCH_CLOSED)
        else $error("switch closed after bus timeout");
    por_open_a: assert property (pc == POR_MASK_CYCLES + 3 |-> !O_SWITCH_CLOSED)
        else $error("switch closed after long supply dip");
    pins_clear_a: assert property (own && O_COMMAND.cmd == CMD_CLEAR |->
        ##[0:1] (O_GPIO.oe == 3'h0))
        else $error("pins not inputs after clear");
    pins_ctrl_a: assert property (own && O_SWITCH_CLOSED && O_COMMAND.cmd == CMD_IO_CTRL
        |-> ##[0:1] (O_GPIO.oe == O_COMMAND.data[6:4] && O_GPIO.o == O_COMMAND.data[2:0]))
        else $error("pin drive differs from command");
    addr_hold_a: assert property ($changed(O_ADDRESS) |-> ##[0:1]
        (O_WORD_VALID && O_COMMAND.cmd == CMD_INIT))
        else $error("address changed without init");
    test_entry_a: assert property ($rose(O_TEST_MODE) |-> ##[0:1]
        (O_WORD_VALID && O_COMMAND.cmd == CMD_TEST_REG && I_TEST_ENABLE_PIN))
        else $error("test mode entered wrongly");
    test_out_a: assert property (O_TEST_OBSERVE_OUT |-> O_TEST_MODE)
        else $error("test output outside test mode");
    cover property (O_WORD_VALID);
    cover property ($rose(O_SWITCH_CLOSED));
    cover property ($fell(O_SWITCH_CLOSED));
    cover property ($rose(O_TEST_MODE));
endmodule : sensor_bus_properties
bind sensor_bus_slave sensor_bus_properties #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .POR_MASK_CYCLES(POR_MASK_CYCLES)
) sensor_bus_properties_i (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_BELOW_FRAME(I_BELOW_FRAME), .I_POR_LOW(I_POR_LOW),
    .I_TEST_ENABLE_PIN(I_TEST_ENABLE_PIN), .O_SWITCH_CLOSED(O_SWITCH_CLOSED),
    .O_RESPONSE_CURRENT(O_RESPONSE_CURRENT), .O_GPIO(O_GPIO),
    .O_TEST_OBSERVE_OUT(O_TEST_OBSERVE_OUT), .O_TEST_MODE(O_TEST_MODE),
    .O_ADDRESS(O_ADDRESS), .O_WORD_VALID(O_WORD_VALID), .O_COMMAND(O_COMMAND)
);
`default_nettype wire
